// >>> ism_pkg.sv
// shared constants and carrier types for the input source mux block
package ism_pkg;
  // port count and port indices (port e carries no routed function)
  localparam int NPORT = 6;
  localparam int PA = 0, PB = 1, PC = 2, PD = 3, PE = 4, PF = 5;
  // number of a/d channels whose input path is controlled
  localparam int NAN = 16;
  // register offsets on the plain register port
  localparam logic [4:0] A_CAPA = 5'h00;
  localparam logic [4:0] A_SINT = 5'h01;
  localparam logic [4:0] A_TMRB = 5'h02;
  localparam logic [4:0] A_UART = 5'h03;
  localparam logic [4:0] A_UNLK = 5'h04;
  localparam logic [4:0] A_STAT = 5'h05;
  localparam logic [4:0] A_WAKE = 5'h06;
  // port data latches at 0x08+n, port direction at 0x10+n
  localparam logic [1:0] A_DATA = 2'h1;
  localparam logic [1:0] A_DIR = 2'h2;
  // capture select a field positions
  localparam int CA_PTP1 = 4, CA_PTP0 = 3, CA_STP2 = 2, CA_STP1 = 1, CA_STP0 = 0;
  // serial and interrupt select field positions
  localparam int SI_CS = 6, SI_SDI = 5, SI_SCK = 4;
  localparam int SI_INT3 = 3, SI_INT2 = 2, SI_INT1 = 1, SI_INT0 = 0;
  // timer select b field positions
  localparam int TB_CK7 = 7, TB_CK6 = 6, TB_PTP6 = 2, TB_PTP5 = 1, TB_PTP4 = 0;
  // uart select field positions
  localparam int UR_RX1 = 1, UR_RX0 = 0;
  // reset values and the unlock pattern
  localparam logic [7:0] SEL_RST = 8'h00;
  localparam logic [7:0] PORT_RST = 8'hFF;
  localparam logic [7:0] UNLOCK_KEY = 8'hCA;
  // level driven to a function input whose selector is reserved
  localparam logic RSV_LVL = 1'b0;
  // write kinds: whole byte, or single bit set / clear
  typedef enum logic [1:0] {
    OP_BYTE = 2'b00,
    OP_SET = 2'b01,
    OP_CLR = 2'b10
  } ism_op_e;
  // one byte per port
  typedef logic [NPORT-1:0][7:0] ism_port_t;
  // alternate-function inputs after source selection
  typedef struct packed {
    logic [2:0] std_cap;
    logic ptcap0;
    logic ptcap1;
    logic ptcap4;
    logic ptcap5;
    logic ptcap6;
    logic ptclk6;
    logic ptclk7;
    logic cs_in;
    logic data_in;
    logic clk_in;
    logic [3:0] ext_int;
    logic [1:0] rx;
  } ism_fn_s;
  // whole state of the block
  typedef struct packed {
    logic [6:0] cap_a;
    logic [6:0] ser_int;
    logic [7:0] tmr_b;
    logic [1:0] uart;
    logic [7:0] unlock;
    logic mode;
    logic [7:0] wake_en;
    ism_port_t data;
    ism_port_t dir;
    logic [7:0] pa_prev;
    logic wake;
    ism_fn_s fn;
    logic [7:0] rdata;
    logic [NAN-1:0] ad_path;
  } ism_state_s;
endpackage : ism_pkg

// >>> ism_top.sv
// input source mux, port read-back test mode, port latches and wake-up
`timescale 1ns/1ns
module ism_top
  import ism_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // register port
  input wire logic [4:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire ism_op_e BIT_OP,
  input wire logic [2:0] BIT_IDX,
  output logic [7:0] RDATA,
  // pins and their selected functions
  input wire ism_port_t PIN_IN,
  input wire ism_port_t PIN_ALT_OUT,
  input wire ism_port_t PIN_SERIAL,
  input wire ism_port_t PIN_ANALOG,
  // a/d channel choice and pin function choice
  input wire logic [3:0] AD_CHAN,
  input wire logic [NAN-1:0] AN_FUNC_SEL,
  // power state
  input wire logic SLEEP,
  // routed function inputs and port state
  output ism_fn_s FN_IN,
  output ism_port_t PORT_DATA,
  output ism_port_t PORT_DIR,
  output logic READBACK_MODE,
  output logic [NAN-1:0] AD_PATH_ON,
  output logic WAKE
);

  // registered and next state
  ism_state_s r;
  ism_state_s n;
  // current view of the addressed register
  logic [7:0] cur;
  // value to be written after bit modify
  logic [7:0] wv;
  // port index taken from the low address bits
  logic [2:0] pidx;
  // address hits one of the port regions
  logic port_hit;

  // what a port read returns for each bit
  function automatic logic [7:0] port_view(
    input logic [7:0] pin,
    input logic [7:0] lat,
    input logic [7:0] dir,
    input logic [7:0] alt,
    input logic [7:0] ser,
    input logic [7:0] ana,
    input logic mode
  );
    logic [7:0] v;
    v = 8'h00;
    for (int b = 0; b < 8; b++) begin
      if (mode) begin
        v[b] = pin[b];
      end else if (ana[b]) begin
        v[b] = 1'b0;
      end else if (ser[b]) begin
        v[b] = pin[b];
      end else if (alt[b]) begin
        v[b] = dir[b] ? 1'b0 : lat[b];
      end else begin
        // plain i/o reads the pin in either direction
        v[b] = pin[b];
      end
    end
    return v;
  endfunction : port_view

  // pick one of two pins, a reserved code giving the idle level
  // reserved drives idle
  function automatic logic pick(
    input logic sel,
    input logic p0,
    input logic p1,
    input logic rsv0,
    input logic rsv1
  );
    logic v;
    v = sel ? (rsv1 ? RSV_LVL : p1) : (rsv0 ? RSV_LVL : p0);
    return v;
  endfunction : pick

  // next state: register access, routing, wake and a/d path
  always_comb begin
    n = r;
    pidx = ADDR[2:0];
    port_hit = (pidx < 3'(NPORT)) && (ADDR[4:3] == A_DATA || ADDR[4:3] == A_DIR);
    cur = 8'h00;
    // read view of every register, unmapped reads zero
    if (ADDR == A_CAPA) begin
      cur = {1'b0, r.cap_a};
    end else if (ADDR == A_SINT) begin
      cur = {1'b0, r.ser_int};
    end else if (ADDR == A_TMRB) begin
      cur = r.tmr_b;
    end else if (ADDR == A_UART) begin
      cur = {6'h00, r.uart};
    end else if (ADDR == A_UNLK) begin
      cur = r.unlock;
    end else if (ADDR == A_STAT) begin
      cur = {7'h00, r.mode};
    end else if (ADDR == A_WAKE) begin
      cur = r.wake_en;
    end else if (port_hit && ADDR[4:3] == A_DATA) begin
      cur = port_view(PIN_IN[pidx], r.data[pidx], r.dir[pidx], PIN_ALT_OUT[pidx],
                      PIN_SERIAL[pidx], PIN_ANALOG[pidx], r.mode);
    end else if (port_hit) begin
      cur = r.dir[pidx];
    end
    // modify one bit of whole byte
    unique case (BIT_OP)
      OP_SET: wv = cur | (8'h01 << BIT_IDX);
      OP_CLR: wv = cur & ~(8'h01 << BIT_IDX);
      default: wv = WDATA;
    endcase
    // register writes
    if (WR) begin
      if (ADDR == A_CAPA) begin
        n.cap_a = wv[6:0];
      end else if (ADDR == A_SINT) begin
        n.ser_int = wv[6:0];
      end else if (ADDR == A_TMRB) begin
        // bits 5..3 kept as written; software is to leave them alone
        n.tmr_b = wv;
      end else if (ADDR == A_UART) begin
        n.uart = wv[1:0];
      end else if (ADDR == A_UNLK) begin
        n.unlock = wv;
        n.mode = (wv == UNLOCK_KEY);
      end else if (ADDR == A_WAKE) begin
        n.wake_en = wv;
      end else if (port_hit && ADDR[4:3] == A_DATA) begin
        n.data[pidx] = wv;
      end else if (port_hit) begin
        n.dir[pidx] = wv;
      end
    end
    // read data stands only in the cycle after the strobe
    n.rdata = RD ? cur : 8'h00;
    n.fn.ptcap1 = pick(r.cap_a[CA_PTP1], PIN_IN[PC][4], 1'b0, 1'b0, 1'b1);
    n.fn.ptcap0 = pick(r.cap_a[CA_PTP0], PIN_IN[PC][2], PIN_IN[PF][5], 1'b0, 1'b0);
    n.fn.std_cap[2] = pick(r.cap_a[CA_STP2], PIN_IN[PD][6], PIN_IN[PF][7], 1'b0, 1'b0);
    n.fn.std_cap[1] = pick(r.cap_a[CA_STP1], PIN_IN[PD][0], PIN_IN[PB][6], 1'b0, 1'b0);
    n.fn.std_cap[0] = pick(r.cap_a[CA_STP0], PIN_IN[PC][6], 1'b0, 1'b0, 1'b1);
    n.fn.cs_in = pick(r.ser_int[SI_CS], PIN_IN[PA][1], 1'b0, 1'b0, 1'b1);
    n.fn.data_in = pick(r.ser_int[SI_SDI], PIN_IN[PA][4], PIN_IN[PF][2], 1'b0, 1'b0);
    n.fn.clk_in = pick(r.ser_int[SI_SCK], PIN_IN[PA][5], 1'b0, 1'b0, 1'b1);
    n.fn.ext_int[3] = pick(r.ser_int[SI_INT3], PIN_IN[PA][5], PIN_IN[PC][7], 1'b0, 1'b0);
    n.fn.ext_int[2] = pick(r.ser_int[SI_INT2], PIN_IN[PA][4], PIN_IN[PD][0], 1'b0, 1'b0);
    n.fn.ext_int[1] = pick(r.ser_int[SI_INT1], PIN_IN[PA][3], PIN_IN[PA][7], 1'b0, 1'b0);
    n.fn.ext_int[0] = pick(r.ser_int[SI_INT0], PIN_IN[PA][1], PIN_IN[PA][6], 1'b0, 1'b0);
    n.fn.ptclk7 = pick(r.tmr_b[TB_CK7], 1'b0, PIN_IN[PC][4], 1'b1, 1'b0);
    n.fn.ptclk6 = pick(r.tmr_b[TB_CK6], PIN_IN[PF][2], PIN_IN[PC][2], 1'b0, 1'b0);
    n.fn.ptcap6 = pick(r.tmr_b[TB_PTP6], PIN_IN[PC][7], 1'b0, 1'b0, 1'b1);
    n.fn.ptcap5 = pick(r.tmr_b[TB_PTP5], PIN_IN[PC][5], 1'b0, 1'b0, 1'b1);
    n.fn.ptcap4 = pick(r.tmr_b[TB_PTP4], PIN_IN[PC][3], 1'b0, 1'b0, 1'b1);
    n.fn.rx[1] = pick(r.uart[UR_RX1], PIN_IN[PD][1], PIN_IN[PF][6], 1'b0, 1'b0);
    n.fn.rx[0] = pick(r.uart[UR_RX0], PIN_IN[PA][6], 1'b0, 1'b0, 1'b1);
    // falling edge on enabled port a pin
    n.pa_prev = PIN_IN[PA];
    n.wake = SLEEP && (|(r.wake_en & r.pa_prev & ~PIN_IN[PA]));
    for (int c = 0; c < NAN; c++) begin
      n.ad_path[c] = (AD_CHAN == 4'(c)) && (AN_FUNC_SEL[c] || r.mode);
    end
  end

  // state register; the previous port a sample resets high, so a pin
  // that is low at the first sample after reset reads as a falling edge
  always_ff @(posedge CLK) begin
    if (RST) begin
      r <= '0;
      r.cap_a <= SEL_RST[6:0];
      r.ser_int <= SEL_RST[6:0];
      r.tmr_b <= SEL_RST;
      r.uart <= SEL_RST[1:0];
      r.unlock <= SEL_RST;
      r.data <= {NPORT{PORT_RST}};
      r.dir <= {NPORT{PORT_RST}};
      r.pa_prev <= PORT_RST;
    end else begin
      r <= n;
    end
  end

  // outputs come straight from the state register
  assign RDATA = r.rdata;
  assign FN_IN = r.fn;
  assign PORT_DATA = r.data;
  assign PORT_DIR = r.dir;
  assign READBACK_MODE = r.mode;
  assign AD_PATH_ON = r.ad_path;
  assign WAKE = r.wake;

  // checks on the routed outputs and register behaviour
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  // byte write of the unlock key
  sequence key_wr_s;
    WR && BIT_OP == OP_BYTE && ADDR == A_UNLK && WDATA == UNLOCK_KEY;
  endsequence
  // byte write of anything else to the unlock register
  sequence other_wr_s;
    WR && BIT_OP == OP_BYTE && ADDR == A_UNLK && WDATA != UNLOCK_KEY;
  endsequence
  // read strobe on a port data register
  sequence port_rd_s;
    RD && port_hit && ADDR[4:3] == A_DATA;
  endsequence
  // port data read while read-back is off
  sequence normal_rd_s;
    RD && port_hit && ADDR[4:3] == A_DATA && !READBACK_MODE;
  endsequence
  // single-bit clear of the wake enable
  sequence wake_clr_s;
    WR && BIT_OP == OP_CLR && ADDR == A_WAKE;
  endsequence

  key_mode_on_a: assert property (key_wr_s |=> READBACK_MODE ##1 (READBACK_MODE || $past(WR)))
    else $error("read-back mode not set by key");
  key_mode_off_a: assert property (other_wr_s |=> !READBACK_MODE)
    else $error("read-back mode set by wrong value");
  ptcap1_route_a: assert property (!r.cap_a[CA_PTP1] |=> FN_IN.ptcap1 == $past(PIN_IN[PC][4]))
    else $error("capture one not from port c4");
  ptcap0_route_a: assert property (##1 FN_IN.ptcap0 == $past(r.cap_a[CA_PTP0] ? PIN_IN[PF][5] : PIN_IN[PC][2]))
    else $error("capture zero wrong source");
  int3_route_a: assert property (##1 FN_IN.ext_int[3] == $past(r.ser_int[SI_INT3] ? PIN_IN[PC][7] : PIN_IN[PA][5]))
    else $error("interrupt three wrong source");
  sint_top_a: assert property (RD && ADDR == A_SINT |=> !RDATA[7])
    else $error("serial select top bit not zero");
  uart_zero_a: assert property (RD && ADDR == A_UART |=> RDATA[7:2] == 6'h00)
    else $error("uart select upper bits not zero");
  pin_readback_a: assert property (port_rd_s ##0 READBACK_MODE |=> RDATA == $past(PIN_IN[pidx]))
    else $error("read-back read not pin levels");
  rd_one_cycle_a: assert property (!RD |=> RDATA == 8'h00)
    else $error("read data held beyond one cycle");
  wake_edge_a: assert property (SLEEP && |(r.wake_en & r.pa_prev & ~PIN_IN[PA]) |=> WAKE)
    else $error("wake missed on falling edge");
  reset_high_a: assert property ($past(RST) |-> PORT_DIR == {NPORT{PORT_RST}} && PORT_DATA == {NPORT{PORT_RST}})
    else $error("ports not high after reset");
  ad_force_a: assert property (READBACK_MODE |=> AD_PATH_ON == NAN'(1) << $past(AD_CHAN))
    else $error("a/d path not forced in read-back");
  bit_set_a: assert property (WR && BIT_OP == OP_SET && ADDR == A_WAKE |=> r.wake_en[$past(BIT_IDX)])
    else $error("bit set lost");

  stcap2_route_a: assert property (
    ##1 FN_IN.std_cap[2] == $past(r.cap_a[CA_STP2] ? PIN_IN[PF][7] : PIN_IN[PD][6]))
    else $error("standard capture two wrong source");
  stcap1_route_a: assert property (
    ##1 FN_IN.std_cap[1] == $past(r.cap_a[CA_STP1] ? PIN_IN[PB][6] : PIN_IN[PD][0]))
    else $error("standard capture one wrong source");
  stcap0_route_a: assert property (
    ##1 FN_IN.std_cap[0] == $past(r.cap_a[CA_STP0] ? RSV_LVL : PIN_IN[PC][6]))
    else $error("standard capture zero wrong source");
  cs_route_a: assert property (
    !r.ser_int[SI_CS] |=> FN_IN.cs_in == $past(PIN_IN[PA][1]))
    else $error("chip select not from port a1");
  cs_rsv_a: assert property (
    r.ser_int[SI_CS] |=> FN_IN.cs_in == RSV_LVL)
    else $error("reserved chip select not idle");
  sdi_route_a: assert property (
    ##1 FN_IN.data_in == $past(r.ser_int[SI_SDI] ? PIN_IN[PF][2] : PIN_IN[PA][4]))
    else $error("serial data in wrong source");
  sck_route_a: assert property (
    ##1 FN_IN.clk_in == $past(r.ser_int[SI_SCK] ? RSV_LVL : PIN_IN[PA][5]))
    else $error("serial clock in wrong source");
  int2_route_a: assert property (
    ##1 FN_IN.ext_int[2] == $past(r.ser_int[SI_INT2] ? PIN_IN[PD][0] : PIN_IN[PA][4]))
    else $error("interrupt two wrong source");
  int1_route_a: assert property (
    ##1 FN_IN.ext_int[1] == $past(r.ser_int[SI_INT1] ? PIN_IN[PA][7] : PIN_IN[PA][3]))
    else $error("interrupt one wrong source");
  int0_route_a: assert property (
    ##1 FN_IN.ext_int[0] == $past(r.ser_int[SI_INT0] ? PIN_IN[PA][6] : PIN_IN[PA][1]))
    else $error("interrupt zero wrong source");
  ptclk7_route_a: assert property (
    ##1 FN_IN.ptclk7 == $past(r.tmr_b[TB_CK7] ? PIN_IN[PC][4] : RSV_LVL))
    else $error("periodic clock seven wrong source");
  ptclk6_route_a: assert property (
    ##1 FN_IN.ptclk6 == $past(r.tmr_b[TB_CK6] ? PIN_IN[PC][2] : PIN_IN[PF][2]))
    else $error("periodic clock six wrong source");
  ptcap64_route_a: assert property (
    ##1 {FN_IN.ptcap6, FN_IN.ptcap5, FN_IN.ptcap4} == $past({(r.tmr_b[TB_PTP6] ? RSV_LVL : PIN_IN[PC][7]),
      (r.tmr_b[TB_PTP5] ? RSV_LVL : PIN_IN[PC][5]), (r.tmr_b[TB_PTP4] ? RSV_LVL : PIN_IN[PC][3])}))
    else $error("periodic captures six to four wrong source");
  rx1_route_a: assert property (
    ##1 FN_IN.rx[1] == $past(r.uart[UR_RX1] ? PIN_IN[PF][6] : PIN_IN[PD][1]))
    else $error("uart one receive wrong source");
  rx0_route_a: assert property (
    ##1 FN_IN.rx[0] == $past(r.uart[UR_RX0] ? RSV_LVL : PIN_IN[PA][6]))
    else $error("uart zero receive wrong source");
  ana_zero_a: assert property (
    normal_rd_s |=> (RDATA & $past(PIN_ANALOG[pidx])) == 8'h00)
    else $error("analog pin read not zero");
  out_zero_a: assert property (
    normal_rd_s |=> (RDATA & $past(PIN_ALT_OUT[pidx] & r.dir[pidx] & ~PIN_SERIAL[pidx])) == 8'h00)
    else $error("output pin read not zero");
  out_latch_a: assert property (
    normal_rd_s |=> (RDATA & $past(PIN_ALT_OUT[pidx] & ~r.dir[pidx] & ~PIN_SERIAL[pidx] & ~PIN_ANALOG[pidx]))
      == $past(r.data[pidx] & PIN_ALT_OUT[pidx] & ~r.dir[pidx] & ~PIN_SERIAL[pidx] & ~PIN_ANALOG[pidx]))
    else $error("output pin read not latch");
  bit_clr_a: assert property (
    wake_clr_s |=> !r.wake_en[$past(BIT_IDX)])
    else $error("bit clear lost");
  awake_a: assert property (
    !SLEEP |=> !WAKE)
    else $error("wake raised while awake");
  ad_normal_a: assert property (
    !READBACK_MODE |=> (AD_PATH_ON & ~$past(AN_FUNC_SEL)) == NAN'(0))
    else $error("a/d path on without pin function");
  mode_hold_a: assert property (
    !(WR && ADDR == A_UNLK) |=> READBACK_MODE == $past(READBACK_MODE))
    else $error("read-back mode changed without unlock write");

endmodule : ism_top

// >>> input_source_mux_and_readback_test_tb.sv
// self-checking bench for the input source mux and read-back block
`timescale 1ns/1ns
module input_source_mux_and_readback_test_tb;
  import ism_pkg::*;
  // register port
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] addr = 5'h00;
  logic [7:0] wdata = 8'h00;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  ism_op_e bit_op = OP_BYTE;
  logic [2:0] bit_idx = 3'h0;
  logic [7:0] rdata;
  // pins and function choices
  ism_port_t pin = '0, alt = '0, ser = '0, ana = '0;
  logic [3:0] ad_chan = 4'h3;
  logic [NAN-1:0] an_sel = '0;
  logic sleep = 1'b0;
  // observed outputs
  ism_fn_s fn;
  ism_port_t pdata, pdir;
  logic mode, wake;
  logic [NAN-1:0] ad_on;
  int n_mismatch = 0;
  int total_checks = 0;
  logic [7:0] rv;
  int c;
  // every pair of alternative pins differs here, so a wrong pick shows
  localparam ism_port_t PAT = 48'h00004204403A;

  ism_top dut (.CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s),
    .BIT_OP(bit_op), .BIT_IDX(bit_idx), .RDATA(rdata), .PIN_IN(pin), .PIN_ALT_OUT(alt),
    .PIN_SERIAL(ser), .PIN_ANALOG(ana), .AD_CHAN(ad_chan), .AN_FUNC_SEL(an_sel),
    .SLEEP(sleep), .FN_IN(fn), .PORT_DATA(pdata), .PORT_DIR(pdir),
    .READBACK_MODE(mode), .AD_PATH_ON(ad_on), .WAKE(wake));

  // 100 ns period
  always #50 clk = ~clk;

  // compare and count, case equality so unknowns fail
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string msg);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %0h expected %0h", $time, msg, got, exp);
    end
  endtask : chk

  // settle n edges, then look just after the last one
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wait_n

  // one-cycle write, effect visible after the taking edge
  task automatic wr(input logic [4:0] a, input logic [7:0] d, input ism_op_e op = OP_BYTE,
    input logic [2:0] i = 3'h0);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    bit_op <= op;
    bit_idx <= i;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
    #1;
  endtask : wr

  // one-cycle read, data only in the following cycle
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    d = rdata;
  endtask : rd

  // expected routing; reserved codes give the inactive level
  function automatic ism_fn_s fexp(input ism_port_t p, input logic [7:0] ca, si, tb, ur);
    fexp.std_cap = {ca[2] ? p[PF][7] : p[PD][6], ca[1] ? p[PB][6] : p[PD][0], ca[0] ? RSV_LVL : p[PC][6]};
    fexp.ptcap0 = ca[3] ? p[PF][5] : p[PC][2];
    fexp.ptcap1 = ca[4] ? RSV_LVL : p[PC][4];
    fexp.ptcap4 = tb[0] ? RSV_LVL : p[PC][3];
    fexp.ptcap5 = tb[1] ? RSV_LVL : p[PC][5];
    fexp.ptcap6 = tb[2] ? RSV_LVL : p[PC][7];
    fexp.ptclk6 = tb[6] ? p[PC][2] : p[PF][2];
    fexp.ptclk7 = tb[7] ? p[PC][4] : RSV_LVL;
    fexp.cs_in = si[6] ? RSV_LVL : p[PA][1];
    fexp.data_in = si[5] ? p[PF][2] : p[PA][4];
    fexp.clk_in = si[4] ? RSV_LVL : p[PA][5];
    fexp.ext_int = {si[3] ? p[PC][7] : p[PA][5], si[2] ? p[PD][0] : p[PA][4],
      si[1] ? p[PA][7] : p[PA][3], si[0] ? p[PA][6] : p[PA][1]};
    fexp.rx = {ur[1] ? p[PF][6] : p[PD][1], ur[0] ? RSV_LVL : p[PA][6]};
  endfunction : fexp

  // expected normal-mode port view per pin function
  function automatic logic [7:0] pview(input logic [7:0] p, l, d, a, s, n);
    for (int i = 0; i < 8; i++)
      pview[i] = n[i] ? 1'b0 : s[i] ? p[i] : a[i] ? (d[i] ? 1'b0 : l[i]) : p[i];
  endfunction : pview

  // reset state of ports, mode, a/d path, wake and the serial and interrupt select
  task automatic t_reset;
    chk(pdata, {NPORT{PORT_RST}}, "data reset");
    chk(pdir, {NPORT{PORT_RST}}, "dir reset");
    chk(mode, 1'b0, "mode reset");
    chk(ad_on, 16'h0000, "path reset");
    chk(wake, 1'b0, "wake reset");
    rd(A_SINT, rv);
    chk(rv, SEL_RST, "select reset");
  endtask : t_reset

  // every selector at both codes, two pin patterns
  task automatic t_route;
    logic [7:0] ca, si, tb, ur;
    for (int k = 0; k < 2; k++) begin
      ca = k ? 8'h1F : 8'h00;
      si = k ? 8'h7F : 8'h00;
      tb = k ? 8'hC7 : 8'h00;
      ur = k ? 8'h03 : 8'h00;
      wr(A_CAPA, ca);
      wr(A_SINT, k ? 8'hFF : 8'h00);
      wr(A_TMRB, tb);
      wr(A_UART, k ? 8'hFF : 8'h00);
      rd(A_SINT, rv);
      chk(rv, si, "serial select read");
      rd(A_UART, rv);
      chk(rv, ur, "uart select read");
      rd(A_CAPA, rv);
      chk(rv, ca, "capture select read");
      rd(A_TMRB, rv);
      chk(rv, tb, "timer select read");
      for (int j = 0; j < 2; j++) begin
        @(posedge clk);
        pin <= j ? ~PAT : PAT;
        wait_n(2);
        chk(fn, fexp(j ? ~PAT : PAT, ca, si, tb, ur), "routing");
      end
    end
  endtask : t_route

  // key, near misses, status and a/d path forcing
  task automatic t_unlock;
    wr(A_UNLK, UNLOCK_KEY);
    chk(mode, 1'b1, "key enables");
    wait_n(1);
    chk(ad_on, 16'h0008, "forced path");
    rd(A_UNLK, rv);
    chk(rv, UNLOCK_KEY, "key reads back");
    wr(A_STAT, 8'h00);
    rd(A_STAT, rv);
    chk(rv, 8'h01, "status read only");
    rd(5'h1F, rv);
    chk(rv, 8'h00, "unmapped read");
    wr(A_UNLK, 8'hCB);
    chk(mode, 1'b0, "near key");
    wr(A_UNLK, UNLOCK_KEY);
    wr(A_UNLK, 8'h00, OP_CLR, 3'h7);
    chk(mode, 1'b0, "bit cleared key");
    wait_n(1);
    chk(ad_on, 16'h0000, "path off");
    @(posedge clk);
    an_sel <= 16'h0008;
    wait_n(2);
    chk(ad_on, 16'h0008, "selected path");
    @(posedge clk);
    an_sel <= 16'hFFF7;
    wait_n(2);
    chk(ad_on, 16'h0000, "other channels");
  endtask : t_unlock

  // port view in both modes, mixed functions on port a
  task automatic t_readback;
    @(posedge clk);
    pin[PA] <= 8'hA5;
    alt[PA] <= 8'hF0;
    ana[PA] <= 8'h08;
    ser[PA] <= 8'h03;
    wr({A_DATA, 3'h0}, 8'h3C);
    wr({A_DIR, 3'h0}, 8'h55);
    chk(pdata[PA], 8'h3C, "latch write");
    rd({A_DATA, 3'h0}, rv);
    chk(rv, pview(8'hA5, 8'h3C, 8'h55, 8'hF0, 8'h03, 8'h08), "normal view");
    wr(A_UNLK, UNLOCK_KEY);
    rd({A_DATA, 3'h0}, rv);
    chk(rv, 8'hA5, "pin view");
    wr(A_UNLK, 8'h00);
  endtask : t_readback

  // bit ops write back the whole read view
  task automatic t_rmw;
    @(posedge clk);
    pin[PB] <= 8'h96;
    wr({A_DATA, 3'h1}, 8'h00, OP_SET, 3'h0);
    chk(pdata[PB], 8'h97, "set bit");
    wr({A_DIR, 3'h1}, 8'h00, OP_CLR, 3'h3);
    chk(pdir[PB], 8'hF7, "clear bit");
    rd({A_DIR, 3'h1}, rv);
    chk(rv, 8'hF7, "direction read");
  endtask : t_rmw

  // count wake pulses over four cycles
  task automatic wcount(input logic [7:0] pa, output int n);
    @(posedge clk);
    pin[PA] <= pa;
    n = 0;
    repeat (4) begin
      wait_n(1);
      if (wake === 1'b1) n++;
    end
  endtask : wcount

  // only enabled falling pins wake, only while asleep
  task automatic t_wake;
    wr(A_WAKE, 8'h08);
    wr(A_WAKE, 8'h00, OP_SET, 3'h4);
    wr(A_WAKE, 8'h00, OP_CLR, 3'h3);
    rd(A_WAKE, rv);
    chk(rv, 8'h10, "wake enable bit ops");
    @(posedge clk);
    sleep <= 1'b1;
    wcount(8'hFF, c);
    wcount(8'hF7, c);
    chk(c, 0, "disabled pin");
    wcount(8'hE7, c);
    chk(c, 1, "enabled pin");
    wcount(8'hFF, c);
    @(posedge clk);
    sleep <= 1'b0;
    wcount(8'hEF, c);
    chk(c, 0, "awake");
  endtask : t_wake

  // verdict and end of run
  task automatic finish_test;
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : finish_test

  // hang guard
  initial begin
    #5000000;
    n_mismatch++;
    finish_test();
  end

  // main sequence
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    wait_n(1);
    t_reset();
    t_route();
    t_unlock();
    t_readback();
    t_rmw();
    t_wake();
    finish_test();
  end
endmodule : input_source_mux_and_readback_test_tb
